// [cemc_mode_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module cemc_mode_ctrl (
  input  wire logic        i_ref_clk,       // system clock
  input  wire logic        i_rst,           // sync reset, active high
  input  wire logic        i_boundary,      // instruction boundary strobe
  input  wire logic        i_enter_emu,     // enter_emu_instr executes
  input  wire logic        i_call_native,   // call_native_instr executes
  input  wire logic        i_leave_emu,     // leave_emu_instr executes
  input  wire logic        i_intr_return,   // intr_return_instr / pop status
  input  wire logic [15:0] i_popped_status, // status word from stack
  input  wire logic        i_halt_instr,    // halt_instr executes
  input  wire logic        i_nmi,           // non-maskable request (pin)
  input  wire logic        i_irq_req,       // irq_controller request (pin)
  input  wire logic        i_hold_req,      // bus hold request (pin)
  input  wire logic        i_refresh,       // refresh cycle active
  input  wire logic        i_lock_req,      // native lock prefix active
  input  wire logic        i_seg_fetch,     // access is an opcode fetch
  input  wire logic        i_seg_stack,     // access is a stack access
  input  wire logic        i_flag_wr,       // emulated flag byte write
  input  wire logic [7:0]  i_flag_data,     // emulated flag value
  input  wire logic        i_rf_wr,         // register write
  input  wire logic [3:0]  i_rf_idx,        // native word index
  input  wire logic [15:0] i_rf_data,       // write data
  input  wire logic [1:0]  i_rf_bmask,      // byte mask
  input  wire logic [3:0]  i_rd_idx,        // read index
  output logic             o_emu_status_pin,// high in emulation
  output logic             o_bus_lock_out,  // lock output, active high
  output logic             o_hold_ack,      // bus hold acknowledge
  output logic             o_standby,       // halted in standby
  output logic             o_vector_take,   // take interrupt vector now
  output logic [15:0]      o_status_word,   // status word
  output logic [15:0]      o_push_status,   // status word to push
  output logic [1:0]       o_seg_sel,       // segment register select
  output logic [3:0]       o_stack_ptr_idx, // active stack pointer
  output logic [15:0]      o_rd_data        // register read data
);
  cemc_ctrl_if rfb ();

  // pin synchronisers
  logic [1:0] nmi_s_q,  nmi_s_d;
  logic [1:0] irq_s_q,  irq_s_d;
  logic [1:0] hold_s_q, hold_s_d;

  // mode state
  cemc_pkg::cemc_mode_t mode_q, mode_d;       // current mode
  cemc_pkg::cemc_mode_t pend_q, pend_d;       // mode for next boundary
  logic                 pend_v_q, pend_v_d;   // pending change
  logic                 md_wen_q, md_wen_d;   // mode flag writable
  logic [15:0]          stat_q, stat_d;       // status word
  logic                 stby_q, stby_d;       // standby
  logic                 vec_q, vec_d;         // vector take pulse
  logic                 pin_q, pin_d;         // status pin
  logic                 lock_q, lock_d;       // lock pin
  logic                 hack_q, hack_d;       // hold ack
  logic [15:0]          push_q, push_d;       // pushed status
  logic [1:0]           seg_q, seg_d;         // segment select
  logic [3:0]           sp_q, sp_d;           // stack pointer index
  logic                 ie;                   // interrupt enable bit

  assign ie = stat_q[9];

  // synchroniser shift
  always_comb begin
    nmi_s_d  = {nmi_s_q[0], i_nmi};
    irq_s_d  = {irq_s_q[0], i_irq_req};
    hold_s_d = {hold_s_q[0], i_hold_req};
  end

  // mode, status and standby next state
  always_comb begin
    mode_d   = mode_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    md_wen_d = md_wen_q;
    stat_d   = stat_q;
    stby_d   = stby_q;
    vec_d    = 1'b0;
    push_d   = push_q;
    if (i_flag_wr && mode_q == cemc_pkg::CEMC_EMU) begin
      stat_d[7:0] = i_flag_data;
    end
    if (stby_q) begin
      // wakeup choices; hold still served while halted
      if (nmi_s_q[1] || (irq_s_q[1] && ie)) begin
        stby_d = 1'b0;
        vec_d  = 1'b1;
        push_d = stat_q;                                   // saved flag keeps mode
        stat_d[cemc_pkg::MODE_BIT] = 1'b1;
        mode_d = cemc_pkg::CEMC_NATIVE;
      end else if (irq_s_q[1]) begin
        stby_d = 1'b0;
      end
    end else if (i_halt_instr) begin
      stby_d = 1'b1;
    end else if (i_enter_emu && mode_q == cemc_pkg::CEMC_NATIVE) begin
      push_d   = stat_q;
      stat_d[cemc_pkg::MODE_BIT] = 1'b0;
      md_wen_d = 1'b1;
      vec_d    = 1'b1;
      pend_d   = cemc_pkg::CEMC_EMU;
      pend_v_d = 1'b1;
    end else if (i_call_native && mode_q == cemc_pkg::CEMC_EMU) begin
      push_d = stat_q;
      push_d[cemc_pkg::MODE_BIT] = 1'b0;
      stat_d[cemc_pkg::MODE_BIT] = 1'b1;
      vec_d    = 1'b1;
      pend_d   = cemc_pkg::CEMC_NATIVE;
      pend_v_d = 1'b1;
    end else if (i_leave_emu && mode_q == cemc_pkg::CEMC_EMU) begin
      stat_d = i_popped_status;
      stat_d[cemc_pkg::MODE_BIT] = 1'b1;
      md_wen_d = 1'b0;
      pend_d   = cemc_pkg::CEMC_NATIVE;
      pend_v_d = 1'b1;
    end else if (i_intr_return) begin
      stat_d[14:0] = i_popped_status[14:0];
      if (md_wen_q) begin
        stat_d[cemc_pkg::MODE_BIT] = i_popped_status[cemc_pkg::MODE_BIT];
        pend_d   = i_popped_status[cemc_pkg::MODE_BIT] ? cemc_pkg::CEMC_NATIVE
                                                        : cemc_pkg::CEMC_EMU;
        pend_v_d = 1'b1;
      end
    end
    if (vec_d && stby_q) begin
      mode_d = cemc_pkg::CEMC_NATIVE;                      // wake is itself a boundary
    end else if (pend_v_q && i_boundary) begin
      mode_d   = pend_q;
      pend_v_d = 1'b0;
    end
  end

  // bus facing outputs
  always_comb begin
    pin_d  = (mode_q == cemc_pkg::CEMC_EMU) ? 1'b1 : i_refresh;
    lock_d = (mode_q == cemc_pkg::CEMC_NATIVE) && i_lock_req;
    hack_d = hold_s_q[1];
    if (mode_q == cemc_pkg::CEMC_EMU) begin
      sp_d = cemc_pkg::REG_ESP;
      if (i_seg_fetch) begin
        seg_d = cemc_pkg::SEG_PS;
      end else begin
        seg_d = cemc_pkg::SEG_DS0;
      end
    end else begin
      sp_d = cemc_pkg::REG_NSP;
      if (i_seg_fetch) begin
        seg_d = cemc_pkg::SEG_PS;
      end else if (i_seg_stack) begin
        seg_d = cemc_pkg::SEG_SS;
      end else begin
        seg_d = cemc_pkg::SEG_DS0;
      end
    end
  end

  // register all state
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      nmi_s_q  <= 2'h0;
      irq_s_q  <= 2'h0;
      hold_s_q <= 2'h0;
      mode_q   <= cemc_pkg::CEMC_NATIVE;
      pend_q   <= cemc_pkg::CEMC_NATIVE;
      pend_v_q <= 1'b0;
      md_wen_q <= 1'b0;
      stat_q   <= cemc_pkg::STATUS_RST;
      stby_q   <= 1'b0;
      vec_q    <= 1'b0;
      pin_q    <= 1'b0;
      lock_q   <= 1'b0;
      hack_q   <= 1'b0;
      push_q   <= 16'h0000;
      seg_q    <= cemc_pkg::SEG_PS;
      sp_q     <= cemc_pkg::REG_NSP;
    end else begin
      nmi_s_q  <= nmi_s_d;
      irq_s_q  <= irq_s_d;
      hold_s_q <= hold_s_d;
      mode_q   <= mode_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      md_wen_q <= md_wen_d;
      stat_q   <= stat_d;
      stby_q   <= stby_d;
      vec_q    <= vec_d;
      pin_q    <= pin_d;
      lock_q   <= lock_d;
      hack_q   <= hack_d;
      push_q   <= push_d;
      seg_q    <= seg_d;
      sp_q     <= sp_d;
    end
  end

  // register file hookup; byte view of the accumulator only
  assign rfb.emu      = (mode_q == cemc_pkg::CEMC_EMU);
  assign rfb.wr_en    = i_rf_wr;
  assign rfb.wr_idx   = i_rf_idx;
  assign rfb.wr_data  = i_rf_data;
  assign rfb.wr_bmask = i_rf_bmask;
  assign rfb.rd_idx   = i_rd_idx;

  cemc_regfile u_rf (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (rfb.rf)
  );

  assign o_emu_status_pin = pin_q;
  assign o_bus_lock_out   = lock_q;
  assign o_hold_ack       = hack_q;
  assign o_standby        = stby_q;
  assign o_vector_take    = vec_q;
  assign o_status_word    = stat_q;
  assign o_push_status    = push_q;
  assign o_seg_sel        = seg_q;
  assign o_stack_ptr_idx  = sp_q;
  assign o_rd_data        = rfb.rd_data;
endmodule : cemc_mode_ctrl
`default_nettype wire

// [cemc_pkg.sv]
package cemc_pkg;

  // cpu operating modes
  typedef enum logic {
    CEMC_NATIVE,
    CEMC_EMU
  } cemc_mode_t;

  // register file indices (16-bit words)
  localparam logic [3:0] REG_ACC   = 4'h0;  // word_accumulator
  localparam logic [3:0] REG_C     = 4'h1;  // gp_word_c
  localparam logic [3:0] REG_D     = 4'h2;  // gp_word_d
  localparam logic [3:0] REG_B     = 4'h3;  // gp_word_b
  localparam logic [3:0] REG_NSP   = 4'h4;  // native_stack_ptr
  localparam logic [3:0] REG_ESP   = 4'h5;  // emu_stack_ptr
  localparam logic [3:0] REG_IX1   = 4'h6;  // index_reg_one
  localparam logic [3:0] REG_IX2   = 4'h7;  // index_reg_two
  localparam logic [3:0] REG_DS1   = 4'h8;  // data_seg_one
  localparam logic [3:0] REG_PS    = 4'h9;  // program_segment
  localparam logic [3:0] REG_SS    = 4'ha;  // stack segment
  localparam logic [3:0] REG_DS0   = 4'hb;  // data_seg_zero
  localparam int         NUM_REGS  = 12;

  // status word layout
  localparam int         MODE_BIT  = 15;    // mode_flag position
  localparam logic [15:0] STATUS_RST = 16'h8000;  // native after reset

  // segment select codes
  localparam logic [1:0] SEG_PS  = 2'h0;
  localparam logic [1:0] SEG_SS  = 2'h1;
  localparam logic [1:0] SEG_DS0 = 2'h2;
  localparam logic [1:0] SEG_DS1 = 2'h3;

endpackage : cemc_pkg

// [cemc_ctrl_if.sv]
`timescale 1ns/1ps
`default_nettype none
// write-protection request path between mode control and register file
interface cemc_ctrl_if;
  logic        emu;       // current mode is emulation
  logic        wr_en;     // write request
  logic [3:0]  wr_idx;    // word index
  logic [15:0] wr_data;   // write data
  logic [1:0]  wr_bmask;  // byte mask {hi,lo}
  logic [3:0]  rd_idx;    // read index
  logic [15:0] rd_data;   // registered read data
  modport ctrl (output emu, wr_en, wr_idx, wr_data, wr_bmask, rd_idx, input rd_data);
  modport rf   (input emu, wr_en, wr_idx, wr_data, wr_bmask, rd_idx, output rd_data);
endinterface : cemc_ctrl_if
`default_nettype wire

// [cemc_regfile.sv]
`timescale 1ns/1ps
`default_nettype none
// native register file with emulation write protection
module cemc_regfile (
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst,
  cemc_ctrl_if.rf    bus
);
  logic [15:0] regs_q [cemc_pkg::NUM_REGS];  // word storage
  logic [15:0] rd_q;                         // registered read data
  logic        lo_ok;                        // low byte writable
  logic        hi_ok;                        // high byte writable

  // emulation may only touch the accumulator low byte and the whole b, c, d and emu stack pointer words
  always_comb begin
    lo_ok = 1'b1;
    hi_ok = 1'b1;
    if (bus.emu) begin
      if (bus.wr_idx == cemc_pkg::REG_ACC) begin
        hi_ok = 1'b0;
      end else if (bus.wr_idx == cemc_pkg::REG_B || bus.wr_idx == cemc_pkg::REG_C
                   || bus.wr_idx == cemc_pkg::REG_D || bus.wr_idx == cemc_pkg::REG_ESP) begin
        lo_ok = 1'b1;
      end else begin
        lo_ok = 1'b0;
        hi_ok = 1'b0;
      end
    end
  end

  // per-word byte writes
  for (genvar g = 0; g < cemc_pkg::NUM_REGS; g++) begin : g_word
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        regs_q[g] <= 16'h0000;
      end else if (bus.wr_en && bus.wr_idx == 4'(g)) begin
        if (bus.wr_bmask[0] && lo_ok) begin
          regs_q[g][7:0] <= bus.wr_data[7:0];
        end
        if (bus.wr_bmask[1] && hi_ok) begin
          regs_q[g][15:8] <= bus.wr_data[15:8];
        end
      end
    end
  end

  // registered read port
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_q <= 16'h0000;
    end else if (32'(bus.rd_idx) < cemc_pkg::NUM_REGS) begin
      rd_q <= regs_q[bus.rd_idx];
    end else begin
      rd_q <= 16'h0000;
    end
  end

  assign bus.rd_data = rd_q;
endmodule : cemc_regfile
`default_nettype wire

// [cemc_mode_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// protocol checker on the mode control top ports
module cemc_mode_ctrl_monitor (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_boundary,
  input  wire logic        i_enter_emu,
  input  wire logic        i_call_native,
  input  wire logic        i_hold_req,
  input  wire logic        i_refresh,
  input  wire logic        i_lock_req,
  input  wire logic        o_emu_status_pin,
  input  wire logic        o_bus_lock_out,
  input  wire logic        o_hold_ack,
  input  wire logic        o_standby,
  input  wire logic        o_vector_take,
  input  wire logic [15:0] o_status_word,
  input  wire logic [15:0] o_push_status,
  input  wire logic [3:0]  o_stack_ptr_idx
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic nat;  // native stack pointer selected
  assign nat = (o_stack_ptr_idx == cemc_pkg::REG_NSP);
  chk_stack_idx_legal: assert property (nat || o_stack_ptr_idx == cemc_pkg::REG_ESP)
    else $error("stack pointer index out of range");
  chk_pin_in_emu: assert property (!nat |-> o_emu_status_pin)
    else $error("status pin low in emulation");
  chk_pin_in_native: assert property (nat |-> o_emu_status_pin == $past(i_refresh))
    else $error("status pin not following refresh in native");
  chk_lock_emu_off: assert property (!nat |-> !o_bus_lock_out)
    else $error("bus lock active in emulation");
  chk_lock_native: assert property (nat |-> o_bus_lock_out == $past(i_lock_req))
    else $error("bus lock not following request in native");
  chk_hold_ack_delay: assert property (o_hold_ack == $past(i_hold_req, 3))
    else $error("hold acknowledge delay wrong");
  chk_vector_one_cycle: assert property (o_vector_take |=> !o_vector_take)
    else $error("vector take longer than one cycle");
  chk_enter_clears_flag: assert property (
    i_enter_emu && nat && o_status_word[15] && !o_standby
    |=> !o_status_word[15] && o_vector_take)
    else $error("enter did not clear mode flag");
  chk_call_sets_flag: assert property (
    i_call_native && !nat && !o_status_word[15] && !o_standby
    |=> o_status_word[15] && !o_push_status[15] && o_vector_take)
    else $error("call native flag handling wrong");
  chk_emu_at_boundary: assert property ($rose(!nat) |-> $past(i_boundary, 2))
    else $error("emulation entered off a boundary");
  cov_vector: cover property (o_vector_take);
  cov_hold: cover property (o_hold_ack);
  cov_wake: cover property (o_standby ##1 !o_standby);
endmodule : cemc_mode_ctrl_monitor
bind cemc_mode_ctrl cemc_mode_ctrl_monitor u_mon (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_boundary(i_boundary),
  .i_enter_emu(i_enter_emu), .i_call_native(i_call_native), .i_hold_req(i_hold_req),
  .i_refresh(i_refresh), .i_lock_req(i_lock_req), .o_emu_status_pin(o_emu_status_pin),
  .o_bus_lock_out(o_bus_lock_out), .o_hold_ack(o_hold_ack), .o_standby(o_standby),
  .o_vector_take(o_vector_take), .o_status_word(o_status_word),
  .o_push_status(o_push_status), .o_stack_ptr_idx(o_stack_ptr_idx));
`default_nettype wire

// [cemc_bus_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// bus master asking for the bus; keeps request until granted
module cemc_bus_peer (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_go,        // start one hold request
  input  wire logic i_hold_ack,  // grant from the cpu
  output logic      o_hold_req,  // hold request level
  output logic      o_done       // one cycle after grant seen
);
  // request held until the grant, then released
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_hold_req <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_done <= o_hold_req && i_hold_ack;
      if (i_go) begin
        o_hold_req <= 1'b1;
      end else if (i_hold_ack) begin
        o_hold_req <= 1'b0;
      end
    end
  end
endmodule : cemc_bus_peer
`default_nettype wire

// [cemc_mode_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cemc_mode_ctrl_bench;
  logic i_ref_clk, i_rst, i_boundary, i_nmi, i_irq_req, i_hold_req, i_refresh, i_lock_req;
  logic i_enter_emu, i_call_native, i_leave_emu, i_intr_return, i_halt_instr;
  logic i_seg_fetch, i_seg_stack, i_flag_wr, i_rf_wr, go, done;
  logic [15:0] i_popped_status, i_rf_data, o_status_word, o_push_status, o_rd_data;
  logic [7:0]  i_flag_data;
  logic [3:0]  i_rf_idx, i_rd_idx, o_stack_ptr_idx;
  logic [1:0]  i_rf_bmask, o_seg_sel;
  logic        o_emu_status_pin, o_bus_lock_out, o_hold_ack, o_standby, o_vector_take;
  int          mismatches, comparisons;
  localparam logic [3:0] NSP = cemc_pkg::REG_NSP;
  localparam logic [3:0] ESP = cemc_pkg::REG_ESP;
  cemc_mode_ctrl DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_boundary(i_boundary),
    .i_enter_emu(i_enter_emu), .i_call_native(i_call_native), .i_leave_emu(i_leave_emu),
    .i_intr_return(i_intr_return), .i_popped_status(i_popped_status),
    .i_halt_instr(i_halt_instr), .i_nmi(i_nmi), .i_irq_req(i_irq_req),
    .i_hold_req(i_hold_req), .i_refresh(i_refresh), .i_lock_req(i_lock_req),
    .i_seg_fetch(i_seg_fetch), .i_seg_stack(i_seg_stack), .i_flag_wr(i_flag_wr),
    .i_flag_data(i_flag_data), .i_rf_wr(i_rf_wr), .i_rf_idx(i_rf_idx),
    .i_rf_data(i_rf_data), .i_rf_bmask(i_rf_bmask), .i_rd_idx(i_rd_idx),
    .o_emu_status_pin(o_emu_status_pin), .o_bus_lock_out(o_bus_lock_out),
    .o_hold_ack(o_hold_ack), .o_standby(o_standby), .o_vector_take(o_vector_take),
    .o_status_word(o_status_word), .o_push_status(o_push_status),
    .o_seg_sel(o_seg_sel), .o_stack_ptr_idx(o_stack_ptr_idx), .o_rd_data(o_rd_data));
  cemc_bus_peer u_peer (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_go(go),
    .i_hold_ack(o_hold_ack), .o_hold_req(i_hold_req), .o_done(done));
  // 200 mhz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // inputs move 1 ns after the edge
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // boundaries until the wanted stack pointer shows
  task automatic bound(input logic [3:0] want);
    for (int k = 0; k < 20 && o_stack_ptr_idx !== want; k++) begin
      i_boundary = 1'b1;
      cyc();
      i_boundary = 1'b0;
      cyc(2);
    end
    chk("stack_ptr", 16'(o_stack_ptr_idx), 16'(want));
  endtask : bound
  // one decoder pulse {halt,enter,call,leave,return}
  task automatic exec(input logic [4:0] p, input logic [15:0] pop, input logic [3:0] want);
    {i_halt_instr, i_enter_emu, i_call_native, i_leave_emu, i_intr_return} = p;
    i_popped_status = pop;
    cyc();
    {i_halt_instr, i_enter_emu, i_call_native, i_leave_emu, i_intr_return} = 5'h00;
    bound(want);
  endtask : exec
  // halt, then wake by nmi or irq pin
  task automatic halt_wake(input logic nmi, input logic [3:0] want);
    exec(5'h10, 16'h0000, o_stack_ptr_idx);
    cyc(3);
    chk("standby", 16'(o_standby), 16'h0001);
    i_nmi = nmi;
    i_irq_req = !nmi;
    for (int k = 0; k < 20 && o_standby !== 1'b0; k++) cyc();
    i_nmi = 1'b0;
    i_irq_req = 1'b0;
    chk("woken", 16'(o_standby), 16'h0000);
    chk("vector_take", 16'(o_vector_take), 16'(want == NSP));
    i_boundary = 1'b1;
    cyc();
    i_boundary = 1'b0;
    cyc(3);
    bound(want);
  endtask : halt_wake
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    i_rf_wr = 1'b1;
    i_rf_idx = idx;
    i_rf_data = d;
    cyc();
    i_rf_wr = 1'b0;
    cyc();
  endtask : wr
  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    i_rd_idx = idx;
    cyc(2);
    chk("reg_read", o_rd_data, exp);
  endtask : rd
  task automatic t_enter;
    wr(cemc_pkg::REG_ACC, 16'habcd);
    wr(cemc_pkg::REG_IX1, 16'h1111);
    i_lock_req = 1'b1;
    exec(5'h08, 16'h0000, ESP);
    chk("mode_flag", 16'(o_status_word[15]), 16'h0000);
    chk("emu_pin", 16'(o_emu_status_pin), 16'h0001);
    chk("bus_lock", 16'(o_bus_lock_out), 16'h0000);
    i_lock_req = 1'b0;
    i_seg_fetch = 1'b1;
    cyc(2);
    chk("seg_fetch", 16'(o_seg_sel), 16'(cemc_pkg::SEG_PS));
    i_seg_fetch = 1'b0;
    i_seg_stack = 1'b1;
    cyc(2);
    chk("seg_stack", 16'(o_seg_sel), 16'(cemc_pkg::SEG_DS0));
    i_seg_stack = 1'b0;
    cyc(2);
    chk("seg_data", 16'(o_seg_sel), 16'(cemc_pkg::SEG_DS0));
  endtask : t_enter
  task automatic t_emu_regs;
    wr(cemc_pkg::REG_ACC, 16'h1234);
    wr(cemc_pkg::REG_IX1, 16'h5555);
    wr(cemc_pkg::REG_B, 16'hbeef);
    rd(cemc_pkg::REG_ACC, 16'hab34);
    rd(cemc_pkg::REG_IX1, 16'h1111);
    rd(cemc_pkg::REG_B, 16'hbeef);
    i_flag_wr = 1'b1;
    i_flag_data = 8'h5a;
    cyc();
    i_flag_wr = 1'b0;
    cyc(2);
    chk("flags", o_status_word, 16'h005a);
  endtask : t_emu_regs
  task automatic t_hold;
    go = 1'b1;
    cyc();
    go = 1'b0;
    for (int k = 0; k < 12 && done !== 1'b1; k++) cyc();
    chk("hold_done", 16'(done), 16'h0001);
    chk("emu_pin", 16'(o_emu_status_pin), 16'h0001);
  endtask : t_hold
  task automatic t_modes;
    halt_wake(1'b0, ESP);
    exec(5'h04, 16'h0000, NSP);
    chk("mode_flag", 16'(o_status_word[15]), 16'h0001);
    chk("push_status", o_push_status, 16'h005a);
    exec(5'h01, 16'h0200, ESP);
    chk("status", o_status_word, 16'h0200);
    halt_wake(1'b0, NSP);
    chk("push_status", o_push_status, 16'h0200);
    exec(5'h01, 16'h0200, ESP);
    halt_wake(1'b1, NSP);
    exec(5'h01, 16'h0200, ESP);
  endtask : t_modes
  task automatic t_leave;
    exec(5'h02, 16'h8000, NSP);
    chk("emu_pin", 16'(o_emu_status_pin), 16'h0000);
    i_refresh = 1'b1;
    cyc(2);
    chk("refresh_pin", 16'(o_emu_status_pin), 16'h0001);
    i_refresh = 1'b0;
    i_lock_req = 1'b1;
    cyc(2);
    chk("bus_lock", 16'(o_bus_lock_out), 16'h0001);
    i_lock_req = 1'b0;
    exec(5'h01, 16'h0200, NSP);
    i_boundary = 1'b1;
    cyc();
    i_boundary = 1'b0;
    cyc(4);
    chk("locked_flag", 16'(o_status_word[15]), 16'h0001);
    halt_wake(1'b0, NSP);
    halt_wake(1'b1, NSP);
  endtask : t_leave
  // reset ends an emulation standby and lands in native mode
  task automatic t_reset;
    exec(5'h08, 16'h0000, ESP);
    exec(5'h10, 16'h0000, ESP);
    cyc(3);
    chk("standby", 16'(o_standby), 16'h0001);
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    cyc();
    chk("reset_wake", 16'(o_standby), 16'h0000);
    chk("reset_status", o_status_word, cemc_pkg::STATUS_RST);
    chk("reset_stack", 16'(o_stack_ptr_idx), 16'(NSP));
  endtask : t_reset
  task automatic wrap_up;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // watchdog well beyond the expected run
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {i_boundary, i_nmi, i_irq_req, i_refresh, i_lock_req, go} = 6'h00;
    {i_halt_instr, i_enter_emu, i_call_native, i_leave_emu, i_intr_return} = 5'h00;
    {i_seg_fetch, i_seg_stack, i_flag_wr, i_rf_wr} = 4'h0;
    {i_popped_status, i_rf_data, i_flag_data} = 40'h0;
    {i_rf_idx, i_rd_idx, i_rf_bmask} = 10'h003;
    i_rst = 1'b1;
    cyc(20);
    i_rst = 1'b0;
    cyc();
    chk("status", o_status_word, 16'h8000);
    chk("stack_ptr", 16'(o_stack_ptr_idx), 16'(NSP));
    t_enter();
    t_emu_regs();
    t_hold();
    t_modes();
    t_leave();
    t_reset();
    wrap_up();
  end
endmodule : cemc_mode_ctrl_bench
`default_nettype wire
